// ===== dram_refresh_control.sv
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_control
  import refresh_pkg::*;
#(
  parameter int row_bits = row_width
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register access, byte or single bit
  input wire logic reg_write,
  input wire logic reg_bit_mode,
  input wire logic [2:0] reg_bit_sel,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Processor status
  input wire logic halted,
  input wire logic stopped,
  input wire logic intak_active,
  input wire logic bus_lock_prefix,
  input wire logic bus_idle,
  input wire logic ready_wait,
  // Bus hold
  input wire logic hold_request,
  output logic hold_acknowledge_n,
  // Refresh cycle outputs
  output logic refresh_active,
  output logic refresh_request_n,
  output logic refresh_request_oe,
  output logic memory_request_n,
  output logic memory_strobe_n,
  output logic io_strobe_n,
  output logic [addr_width-1:0] addr_out
);
  logic [6:0] ctl_q;
  logic slave_lv_q;
  logic master_lv_q;
  logic [row_bits-1:0] row_q;
  logic [1:0] wcnt_q;
  logic pend_q;
  logic [2:0] ack_q;
  logic tick;
  logic auto_en;
  logic refr_ok;
  logic [7:0] wmask;
  logic [7:0] wval;
  logic [7:0] cur;
  logic [1:0] waits;
  state_type st_q;
  state_type st_d;

  // ------------------------------------------------------------
  // Register
  // ------------------------------------------------------------
  assign cur = {slave_lv_q, ctl_q};
  assign wmask = reg_bit_mode ? 8'(8'h01 << reg_bit_sel) : 8'hFF;
  assign wval = (cur & ~wmask) | (reg_wdata & wmask);
  assign reg_rdata = {master_lv_q, ctl_q};
  assign auto_en = ctl_q[bit_auto];
  assign waits = ctl_q[bit_wait_lo+1:bit_wait_lo];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_q <= mode_reset[6:0];
      slave_lv_q <= mode_reset[bit_level];
      master_lv_q <= mode_reset[bit_level];
    end else begin
      if (reg_write) begin
        ctl_q <= wval[6:0];
        slave_lv_q <= wval[bit_level];
      end
      if (tick) begin
        master_lv_q <= slave_lv_q;
      end
    end
  end

  refresh_timer #(
    .width(tb_width)
  ) refresh_timer_i (
    .clk(clk),
    .nrst(nrst),
    .sel(ctl_q[bit_int_lo+1:bit_int_lo]),
    .tick(tick)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Pending timing kept until served, so a busy bus only delays it
  assign refr_ok = auto_en && !ready_wait && bus_idle && !stopped
    && (!halted || ctl_q[bit_halt]);

  always_comb begin
    st_d = st_q;
    case (st_q)
      st_run: begin
        if (pend_q && refr_ok) begin
          st_d = st_refr;
        end else if (hold_request && !intak_active && !bus_lock_prefix
                     && !stopped && bus_idle) begin
          st_d = st_ack;
        end
      end
      st_ack: st_d = (ack_q >= 3'(hold_min_clk - 1)) ? st_hold : st_ack;
      st_hold: begin
        if (!hold_request) begin
          st_d = st_rel;
        end else if (pend_q && auto_en && ctl_q[bit_hold]) begin
          st_d = st_drop;
        end
      end
      st_drop: st_d = hold_request ? st_drop : st_refr;
      st_refr: st_d = (waits == 2'h0) ? st_rel : st_wait;
      st_wait: begin
        if (wcnt_q == 2'h1 || (waits == 2'h1)) begin
          st_d = st_rel;
        end
      end
      st_rel: st_d = st_run;
      default: st_d = st_run;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= st_run;
      pend_q <= 1'b0;
      row_q <= '0;
      wcnt_q <= 2'h0;
      ack_q <= 3'h0;
    end else begin
      st_q <= st_d;
      // Set wins over service clear
      if (tick && auto_en) begin
        pend_q <= 1'b1;
      end else if (st_q == st_refr) begin
        pend_q <= 1'b0;
      end
      if (st_q == st_refr) begin
        row_q <= row_q + row_bits'(1);
        wcnt_q <= (waits >= wait_two) ? 2'h0 : 2'h1;
      end else if (st_q == st_wait) begin
        wcnt_q <= wcnt_q + 2'h1;
      end
      ack_q <= (st_q == st_ack) ? ack_q + 3'h1 : 3'h0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign refresh_active = (st_q == st_refr) || (st_q == st_wait);
  assign hold_acknowledge_n = !(st_q == st_hold);
  assign memory_request_n = 1'b1;
  assign memory_strobe_n = 1'b1;
  assign io_strobe_n = 1'b1;
  assign addr_out = refresh_active ?
    {(addr_width - row_bits)'(0), row_q} : '0;
  // Low when level 0, high when level 1 and off, else pulse
  assign refresh_request_n = master_lv_q &&
    !(auto_en && refresh_active);
  // Pin floats in reset and while the bus is lent out
  assign refresh_request_oe = nrst && st_q != st_hold;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  hold_min_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(hold_request) && st_q == st_run |-> ##1 hold_acknowledge_n [*2])
    else $error("hold ack too early");
  hold_max_a: assert property (@(posedge clk) disable iff (!nrst)
    st_q == st_ack |-> ##[1:4] st_q == st_hold)
    else $error("hold ack late");
  lock_block_a: assert property (@(posedge clk) disable iff (!nrst)
    st_q == st_run && bus_lock_prefix && !pend_q |=> st_q != st_ack)
    else $error("hold during lock");
  intak_block_a: assert property (@(posedge clk) disable iff (!nrst)
    st_q == st_run && intak_active |=> st_q != st_ack)
    else $error("hold during intak");
  stop_block_a: assert property (@(posedge clk) disable iff (!nrst)
    st_q == st_run && stopped |=> st_q == st_run)
    else $error("bus moved in stop");
  write_land_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_write && !reg_bit_mode |=> reg_rdata[6:0] == $past(reg_wdata[6:0]))
    else $error("byte write lost");
  wait_none_a: assert property (@(posedge clk) disable iff (!nrst)
    st_q == st_refr && waits == 2'h0 |=> !refresh_active)
    else $error("extra refresh wait");
  auto_off_a: assert property (@(posedge clk) disable iff (!nrst)
    !auto_en && st_q == st_run |=> !refresh_active)
    else $error("refresh while disabled");
  halt_off_a: assert property (@(posedge clk) disable iff (!nrst)
    halted && !ctl_q[bit_halt] && st_q == st_run |=> !refresh_active)
    else $error("halt refresh disallowed");
  hold_force_a: assert property (@(posedge clk) disable iff (!nrst)
    st_q == st_hold && pend_q && auto_en && ctl_q[bit_hold]
    |=> hold_acknowledge_n)
    else $error("ack not forced high");
  pin_low_a: assert property (@(posedge clk) disable iff (!nrst)
    !master_lv_q |-> !refresh_request_n)
    else $error("pin not low");
  pin_high_a: assert property (@(posedge clk) disable iff (!nrst)
    master_lv_q && !auto_en |-> refresh_request_n)
    else $error("pin not high");
  pulse_out_a: assert property (@(posedge clk) disable iff (!nrst)
    refresh_active && auto_en |-> !refresh_request_n)
    else $error("no refresh pulse");
  level_lat_a: assert property (@(posedge clk) disable iff (!nrst)
    tick |=> reg_rdata[bit_level] == $past(slave_lv_q))
    else $error("master not loaded");
  row_addr_a: assert property (@(posedge clk) disable iff (!nrst)
    refresh_active |-> addr_out[addr_width-1:row_bits] == '0
    && addr_out[row_bits-1:0] == row_q)
    else $error("bad refresh address");
  drop_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    st_q == st_drop && hold_request |=> !refresh_active)
    else $error("refresh before release");
  ready_block_a: assert property (@(posedge clk) disable iff (!nrst)
    ready_wait && st_q == st_run |=> st_q != st_refr)
    else $error("refresh in ready wait");
  row_step_a: assert property (@(posedge clk) disable iff (!nrst)
    st_q == st_refr |=> row_q == $past(row_q) + row_bits'(1))
    else $error("row not advanced");
endmodule
`default_nettype wire

// ===== refresh_pkg.sv
package refresh_pkg;
  localparam logic [7:0] mode_reset = 8'hFC;
  localparam int bit_int_lo = 0;
  localparam int bit_wait_lo = 2;
  localparam int bit_auto = 4;
  localparam int bit_halt = 5;
  localparam int bit_hold = 6;
  localparam int bit_level = 7;
  localparam int tap_base = 4;
  localparam int row_width = 9;
  localparam int addr_width = 20;
  localparam int tb_width = 8;
  localparam int hold_min_clk = 3;
  localparam logic [1:0] wait_two = 2'h2;

  typedef enum logic [2:0] {
    st_run = 3'h0,
    st_ack = 3'h1,
    st_hold = 3'h3,
    st_drop = 3'h2,
    st_refr = 3'h6,
    st_wait = 3'h7,
    st_rel = 3'h5
  } state_type;
endpackage

// ===== refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none
module refresh_timer
  import refresh_pkg::*;
#(
  parameter int width = tb_width
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Tap select
  input wire logic [1:0] sel,
  output logic tick
);
  logic [width-1:0] cnt_q;
  logic [width-1:0] mask;

  // Tap 3 to 6 gives period 2^(4+sel)
  assign mask = width'((1 << (tap_base + int'(sel))) - 1);
  assign tick = (cnt_q & mask) == mask;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + width'(1);
    end
  end
endmodule
`default_nettype wire

// ===== refresh_partner.sv
`timescale 1ns/1ps
`default_nettype none
module refresh_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus master side
  input wire logic want,
  input wire logic hold_acknowledge_n,
  input wire logic refresh_request_n,
  output logic hold_request
);
  logic granted_q;
  // Request dropped while acknowledge is forced high, until refresh pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) granted_q <= 1'b0;
    else if (!want || !refresh_request_n) granted_q <= 1'b0;
    else if (!hold_acknowledge_n) granted_q <= 1'b1;
  end
  assign hold_request = want && !(granted_q && hold_acknowledge_n);
endmodule
`default_nettype wire

// ===== dram_refresh_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_control_test;
  import refresh_pkg::*;
  logic clk, nrst, reg_write, reg_bit_mode, ready_wait, intak, want;
  logic halted, stopped, lock;
  logic [2:0] reg_bit_sel;
  logic [7:0] reg_wdata;
  wire logic [7:0] rd;
  wire logic hreq, ack_n, act, req_n, oe, mr_n, ms_n, io_n;
  wire logic [addr_width-1:0] addr;
  wire logic [1:0] sig = {ack_n, act};
  int n_mismatch = 0;
  int total_checks = 0;
  int t;
  logic acc;
  logic [8:0] row;
  dram_refresh_control dram_refresh_control_i (.clk(clk), .nrst(nrst),
    .reg_write(reg_write), .reg_bit_mode(reg_bit_mode),
    .reg_bit_sel(reg_bit_sel), .reg_wdata(reg_wdata), .reg_rdata(rd),
    .halted(halted), .stopped(stopped), .intak_active(intak),
    .bus_lock_prefix(lock), .bus_idle(1'b1), .ready_wait(ready_wait),
    .hold_request(hreq), .hold_acknowledge_n(ack_n), .refresh_active(act),
    .refresh_request_n(req_n), .refresh_request_oe(oe),
    .memory_request_n(mr_n), .memory_strobe_n(ms_n), .io_strobe_n(io_n),
    .addr_out(addr));
  refresh_partner refresh_partner_i (.clk(clk), .nrst(nrst), .want(want),
    .hold_acknowledge_n(ack_n), .refresh_request_n(req_n),
    .hold_request(hreq));
  // ----------------
  // Shared tasks
  // ----------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait; a hang counts as a mismatch
  task automatic wait_sig(input int w, input logic lvl, output int n);
    n = 0;
    while (sig[w] !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        n_mismatch++;
        wrap_up();
      end
    end
  endtask
  task automatic wr(input logic bm, input logic [2:0] s, input logic [7:0] d);
    @(negedge clk);
    reg_write = 1;
    reg_bit_mode = bm;
    reg_bit_sel = s;
    reg_wdata = d;
    @(negedge clk);
    reg_write = 0;
  endtask
  // Length and spacing of refresh cycles for every wait and interval code
  task automatic cycles();
    for (int i = 0; i < 4; i++) begin
      wr(0, 0, {4'hF, i[1:0], i[1:0]});
      wait_sig(0, 0, t);
      wait_sig(0, 1, t);
      row = addr[8:0];
      chk(addr[19:9], 0);
      chk({mr_n, ms_n, io_n, req_n}, 4'hE);
      wait_sig(0, 0, t);
      chk(t, (i > 1) ? 3 : i + 1);
      wait_sig(0, 1, t);
      chk(t + ((i > 1) ? 3 : i + 1), 16 << i);
      chk(addr[8:0], 9'(row + 9'h1));
    end
    $display("cycles done");
  endtask
  task automatic auto_off();
    wr(1, 4, 8'h00);
    chk(rd, 8'hEF);
    acc = 0;
    repeat (300) @(negedge clk) acc |= act;
    chk(acc, 0);
    chk(req_n, 1);
    wr(1, 7, 8'h00);
    chk(rd[7], 1);
    repeat (140) @(negedge clk);
    chk({rd[7], req_n}, 0);
    $display("auto_off done");
  endtask
  task automatic hold();
    wr(0, 0, 8'h80);
    want = 1;
    wait_sig(1, 0, t);
    chk(t >= 3 && t <= 7, 1);
    wr(0, 0, 8'hD0);
    wait_sig(1, 1, t);
    chk(t <= 20, 1);
    wait_sig(0, 1, t);
    chk(t <= 8, 1);
    wait_sig(1, 0, t);
    chk(t <= 12, 1);
    intak = 1;
    ready_wait = 1;
    want = 0;
    wait_sig(1, 1, t);
    want = 1;
    acc = 0;
    repeat (60) @(negedge clk) acc |= act | !ack_n;
    chk(acc, 0);
    want = 0;
    intak = 0;
    ready_wait = 0;
    $display("hold done");
  endtask
  // Halt, bus lock and stop hold off refresh or hold as the bits say
  task automatic status();
    halted = 1;
    lock = 1;
    want = 1;
    acc = 0;
    repeat (60) @(negedge clk) acc |= act | !ack_n;
    chk(acc, 0);
    wr(1, 5, 8'h20);
    wait_sig(0, 1, t);
    chk(t, 1);
    chk(ack_n, 1);
    wr(1, 4, 8'h00);
    acc = 0;
    repeat (60) @(negedge clk) acc |= act;
    chk(acc, 0);
    {halted, lock, stopped} = 3'h1;
    wr(1, 4, 8'h10);
    acc = 0;
    repeat (60) @(negedge clk) acc |= act | !ack_n;
    chk(acc, 0);
    stopped = 0;
    wait_sig(1, 0, t);
    chk(t >= 7 && t <= 10, 1);
    want = 0;
    wait_sig(1, 1, t);
    $display("status done");
  endtask
  task automatic reset_state();
    repeat (3) @(negedge clk);
    chk(oe, 0);
    chk(rd, 8'hFC);
    nrst = 1;
    @(negedge clk);
    chk(oe, 1);
    $display("reset done");
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    {nrst, reg_write, reg_bit_mode, ready_wait, intak, want} = '0;
    {halted, stopped, lock} = '0;
    reg_bit_sel = '0;
    reg_wdata = '0;
    reset_state();
    cycles();
    auto_off();
    hold();
    status();
    wrap_up();
  end
endmodule
`default_nettype wire
